//--- logic/nvra_array.v
`timescale 1ns/1ps

// ****************************************
// byte array, linear addressing
// ****************************************
module nvra_array #(
   parameter ADDR_W = 12,
   parameter DATA_W = 8
) (
   input  wire              clk_i,
   input  wire              wr_en_i,
   input  wire [ADDR_W-1:0] addr_i,
   input  wire [DATA_W-1:0] wdata_i,
   output wire [DATA_W-1:0] rdata_o
);

   reg [DATA_W-1:0] cells [0:(1<<ADDR_W)-1];
   integer          i;

   // blank part starts fully erased
   initial begin
      for (i = 0; i < (1<<ADDR_W); i = i + 1) begin
         cells[i] = {DATA_W{1'b1}};
      end
   end

   always @(posedge clk_i) begin
      if (wr_en_i) begin
         cells[addr_i] <= wdata_i;
      end
   end

   // read is asynchronous so a read strobe sees the byte at once
   assign rdata_o = cells[addr_i];

endmodule // nvra_array

//--- logic/nvra_defs.vh
`ifndef NVRA_DEFS_VH
`define NVRA_DEFS_VH

// ****************************************
// register offsets in the io space
// ****************************************
`define NVRA_OFF_CONTROL      6'h1f
`define NVRA_OFF_BYTE_VALUE   6'h20
`define NVRA_OFF_ADDRESS_LOW  6'h21
`define NVRA_OFF_ADDRESS_HIGH 6'h22

// ****************************************
// control field positions
// ****************************************
`define NVRA_BIT_READ_STROBE     0
`define NVRA_BIT_PROGRAM_STROBE  1
`define NVRA_BIT_PROGRAM_ARM     2
`define NVRA_BIT_READY_IRQ_EN    3
`define NVRA_BIT_ACTION_LO       4
`define NVRA_BIT_ACTION_HI       5

// ****************************************
// action encodings
// ****************************************
`define NVRA_ACT_ATOMIC     2'h0
`define NVRA_ACT_ERASE      2'h1
`define NVRA_ACT_WRITE      2'h2
`define NVRA_ACT_RESERVED   2'h3

// ****************************************
// reset values
// ****************************************
`define NVRA_RST_BYTE_VALUE 8'h00
`define NVRA_RST_ADDRESS    12'h000
`define NVRA_RST_ACTION     2'h0
`define NVRA_ERASED_BYTE    8'hff

// ****************************************
// timing
// ****************************************
`define NVRA_CLK_KHZ        25000
`define NVRA_T_ATOMIC_US    3400
`define NVRA_T_SPLIT_US     1800
`define NVRA_ARM_CYCLES     3'h4
`define NVRA_READ_HALT      3'h4
`define NVRA_PROG_HALT      3'h2

`endif

//--- logic/nvra_top.v
`timescale 1ns/1ps
`include "nvra_defs.vh"

// Behaviour
// - unused address-high bits 7:4 and control bits 7:6 read as zero
// - twelve-bit byte address from high and low registers selects one array byte
// - atomic programming writes the data register byte at the selected address; write ANDs it in, erase writes ff
// - read places the addressed byte into the data register
// - action-select field chooses the action started by the program strobe
// - 00 atomic 3.4ms, 01 erase 1.8ms, 10 write 1.8ms, 11 reserved
// - action-select writes are ignored while the program strobe is set
// - reset clears action-select to 00 unless programming is running
// - arm clears four cycles after set; strobe starts only while armed
// - program strobe stays set for the whole programming time
// - read strobe loads data at once and stalls the cpu four cycles
// - no read and no address change while programming
module nvra_top #(
   parameter ADDR_W     = 12,
   parameter CNT_W      = 17,
   parameter ATOMIC_CYC = (`NVRA_T_ATOMIC_US * `NVRA_CLK_KHZ) / 1000,
   parameter SPLIT_CYC  = (`NVRA_T_SPLIT_US * `NVRA_CLK_KHZ) / 1000
) (
   input  wire       clk_i,
   input  wire       rstn_i,
   input  wire       por_n_i,
   input  wire [5:0] io_addr_i,
   input  wire       io_wr_i,
   input  wire       io_rd_i,
   input  wire [7:0] io_wdata_i,
   output reg  [7:0] io_rdata_o,
   output wire       cpu_halt_o,
   output wire       ready_irq_o
);

   localparam ST_IDLE = 2'b01;
   localparam ST_PROG = 2'b10;

   localparam integer     ATOMIC_M1   = ATOMIC_CYC - 1;
   localparam integer     SPLIT_M1    = SPLIT_CYC - 1;
   localparam [CNT_W-1:0] ATOMIC_LOAD = ATOMIC_M1[CNT_W-1:0];
   localparam [CNT_W-1:0] SPLIT_LOAD  = SPLIT_M1[CNT_W-1:0];
   localparam [11:0]      RST_ADDR    = `NVRA_RST_ADDRESS;

   // ****************************************
   // register state
   // ****************************************
   reg  [3:0]        address_high;
   reg  [7:0]        address_low;
   reg  [7:0]        nv_byte_value;
   reg               ready_irq_enable;
   reg  [2:0]        arm_count;
   reg  [2:0]        halt_count;
   reg  [1:0]        rst_pipe;

   // programming engine, power-on clears it; system reset clears only action_select, and only while idle
   reg  [1:0]        state;
   reg  [CNT_W-1:0]  prog_count;
   reg  [1:0]        action_select;
   reg  [1:0]        prog_action;
   reg  [7:0]        prog_data;
   // latched so a system reset cannot move a running write
   reg  [ADDR_W-1:0] prog_addr;

   reg  [7:0]        next_rdata;
   reg  [7:0]        next_cell;
   reg  [CNT_W-1:0]  next_load;

   wire [ADDR_W-1:0] nv_byte_address;
   wire [ADDR_W-1:0] array_addr;
   wire [7:0]        cell_rdata;
   wire              program_strobe;
   wire              program_arm;
   wire              ctrl_wr;
   wire              read_go;
   wire              prog_go;
   wire              prog_done;
   wire              sys_run;

   assign nv_byte_address = {address_high, address_low};
   assign array_addr      = program_strobe ? prog_addr : nv_byte_address;
   assign program_strobe  = (state == ST_PROG);
   assign program_arm     = (arm_count != 3'h0);
   assign sys_run         = rst_pipe[1];
   assign ctrl_wr         = io_wr_i && (io_addr_i == `NVRA_OFF_CONTROL);

   // strobe without a live arm has no effect; reserved code starts nothing
   assign prog_go   = ctrl_wr && io_wdata_i[`NVRA_BIT_PROGRAM_STROBE] && program_arm
                      && !program_strobe
                      && (io_wdata_i[5:4] != `NVRA_ACT_RESERVED);
   assign read_go   = ctrl_wr && io_wdata_i[`NVRA_BIT_READ_STROBE]
                      && !program_strobe;
   assign prog_done = program_strobe && (prog_count == {CNT_W{1'b0}});

   assign cpu_halt_o  = (halt_count != 3'h0);
   assign ready_irq_o = ready_irq_enable && !program_strobe;

   // ****************************************
   // reset release seen by the engine
   // ****************************************
   always @(posedge clk_i or negedge rstn_i) begin
      if (!rstn_i) begin
         rst_pipe <= 2'b00;
      end else begin
         rst_pipe <= {rst_pipe[0], 1'b1};
      end
   end

   // ****************************************
   // software registers
   // ****************************************
   always @(posedge clk_i or negedge rstn_i) begin
      if (!rstn_i) begin
         address_high     <= RST_ADDR[11:8];
         address_low      <= RST_ADDR[7:0];
         nv_byte_value    <= `NVRA_RST_BYTE_VALUE;
         ready_irq_enable <= 1'b0;
      end else begin
         // address frozen while a byte is being programmed
         if (io_wr_i && !program_strobe) begin
            if (io_addr_i == `NVRA_OFF_ADDRESS_HIGH) begin
               address_high <= io_wdata_i[3:0];
            end
            if (io_addr_i == `NVRA_OFF_ADDRESS_LOW) begin
               address_low <= io_wdata_i;
            end
         end
         if (read_go) begin
            nv_byte_value <= cell_rdata;
         end else if (io_wr_i && (io_addr_i == `NVRA_OFF_BYTE_VALUE)) begin
            nv_byte_value <= io_wdata_i;
         end
         if (ctrl_wr) begin
            ready_irq_enable <= io_wdata_i[`NVRA_BIT_READY_IRQ_EN];
         end
      end
   end

   // ****************************************
   // arm window and cpu stall
   // ****************************************
   always @(posedge clk_i or negedge rstn_i) begin
      if (!rstn_i) begin
         arm_count  <= 3'h0;
         halt_count <= 3'h0;
      end else begin
         if (ctrl_wr && io_wdata_i[`NVRA_BIT_PROGRAM_ARM]) begin
            arm_count <= `NVRA_ARM_CYCLES;
         end else if (program_arm) begin
            arm_count <= arm_count - 3'h1;
         end
         if (read_go) begin
            halt_count <= `NVRA_READ_HALT;
         end else if (prog_go) begin
            halt_count <= `NVRA_PROG_HALT;
         end else if (cpu_halt_o) begin
            halt_count <= halt_count - 3'h1;
         end
      end
   end

   // ****************************************
   // programming engine
   // ****************************************
   always @* begin
      next_load = SPLIT_LOAD;
      if (io_wdata_i[5:4] == `NVRA_ACT_ATOMIC) begin
         next_load = ATOMIC_LOAD;
      end
   end

   always @* begin
      case (prog_action)
         `NVRA_ACT_ATOMIC: next_cell = prog_data;
         `NVRA_ACT_ERASE:  next_cell = `NVRA_ERASED_BYTE;
         `NVRA_ACT_WRITE:  next_cell = cell_rdata & prog_data;
         default:          next_cell = cell_rdata;
      endcase
   end

   // survives system reset so a running program cycle completes
   always @(posedge clk_i or negedge por_n_i) begin
      if (!por_n_i) begin
         state         <= ST_IDLE;
         prog_count    <= {CNT_W{1'b0}};
         action_select <= `NVRA_RST_ACTION;
         prog_action   <= `NVRA_RST_ACTION;
         prog_data     <= `NVRA_RST_BYTE_VALUE;
         prog_addr     <= {ADDR_W{1'b0}};
      end else begin
         case (state)
            ST_IDLE: begin
               if (!sys_run) begin
                  action_select <= `NVRA_RST_ACTION;
               end else if (ctrl_wr) begin
                  action_select <= io_wdata_i[5:4];
               end
               if (prog_go) begin
                  state       <= ST_PROG;
                  prog_count  <= next_load;
                  prog_action <= io_wdata_i[5:4];
                  prog_data   <= nv_byte_value;
                  prog_addr   <= nv_byte_address;
               end
            end
            ST_PROG: begin
               // action field held, reset included, until done
               if (prog_done) begin
                  state <= ST_IDLE;
               end else begin
                  prog_count <= prog_count - {{(CNT_W-1){1'b0}}, 1'b1};
               end
            end
            default: begin
               state <= ST_IDLE;
            end
         endcase
      end
   end

   nvra_array #(
      .ADDR_W (ADDR_W),
      .DATA_W (8)
   ) u_array (
      .clk_i   (clk_i),
      .wr_en_i (prog_done),
      .addr_i  (array_addr),
      .wdata_i (next_cell),
      .rdata_o (cell_rdata)
   );

   // ****************************************
   // read back
   // ****************************************
   always @* begin
      next_rdata = 8'h00;
      case (io_addr_i)
         `NVRA_OFF_CONTROL:      next_rdata = {2'b00, action_select, ready_irq_enable,
                                               program_arm, program_strobe, 1'b0};
         `NVRA_OFF_BYTE_VALUE:   next_rdata = nv_byte_value;
         `NVRA_OFF_ADDRESS_LOW:  next_rdata = address_low;
         `NVRA_OFF_ADDRESS_HIGH: next_rdata = {4'h0, address_high};
         default:                next_rdata = 8'h00;
      endcase
   end

   always @(posedge clk_i or negedge rstn_i) begin
      if (!rstn_i) begin
         io_rdata_o <= 8'h00;
      end else if (io_rd_i) begin
         io_rdata_o <= next_rdata;
      end
   end

endmodule // nvra_top

//--- testbench/nvra_chk.sv
`timescale 1ns/1ps
// ********************
// port checker
// ********************
module nvra_chk (
   input wire logic       clk_i,
   input wire logic       rstn_i,
   input wire logic       por_n_i,
   input wire logic [5:0] io_addr_i,
   input wire logic       io_wr_i,
   input wire logic       io_rd_i,
   input wire logic [7:0] io_wdata_i,
   input wire logic [7:0] io_rdata_o,
   input wire logic       cpu_halt_o,
   input wire logic       ready_irq_o
);
   default clocking @(posedge clk_i); endclocking
   default disable iff (!rstn_i || !por_n_i);
   wire c_wr = io_wr_i && io_addr_i == 6'h1f;
   // ready high before the arm write proves the engine idle
   sequence s_arm;
      c_wr && io_wdata_i == 8'h0c && ready_irq_o;
   endsequence
   a_ctrl_rsvd: assert property (io_rd_i && io_addr_i == 6'h1f
      |=> io_rdata_o[7:6] == 2'h0 && !io_rdata_o[0]) else $error("control spare bits set");
   a_addr_rsvd: assert property (io_rd_i && io_addr_i == 6'h22
      |=> io_rdata_o[7:4] == 4'h0) else $error("address spare bits set");
   a_prog_start: assert property (s_arm ##2 (c_wr && io_wdata_i[3:0] == 4'ha
      && io_wdata_i[5:4] != 2'h3) |=> (cpu_halt_o && !ready_irq_o)[*2] ##1 !cpu_halt_o)
      else $error("program start wrong");
   a_arm_expire: assert property (s_arm ##1 !io_wr_i[*4] ##1
      (c_wr && io_wdata_i == 8'h0a) |=> ready_irq_o && !cpu_halt_o) else $error("late fire ran");
   a_act_rsvd: assert property (s_arm ##2 (c_wr && io_wdata_i == 8'h3a)
      |=> ready_irq_o && !cpu_halt_o) else $error("reserved action ran");
   a_read_halt: assert property (c_wr && io_wdata_i == 8'h09 && ready_irq_o
      |=> cpu_halt_o[*4] ##1 !cpu_halt_o) else $error("read stall length wrong");
   a_busy_read: assert property (c_wr && io_wdata_i[0] && io_wdata_i[3]
      |=> ready_irq_o || !cpu_halt_o) else $error("read ran while busy");
   a_irq_off: assert property (c_wr && !io_wdata_i[3]
      |=> !ready_irq_o) else $error("ready level without enable");
   cover property (s_arm ##2 (c_wr && io_wdata_i[3:0] == 4'ha));
   cover property (c_wr && io_wdata_i == 8'h09 && ready_irq_o);
   cover property (c_wr && io_wdata_i[0] && !ready_irq_o);
endmodule // nvra_chk

//--- testbench/testbench.sv
`timescale 1ns/1ps
module testbench;
   logic       clk_i, rstn_i, por_n_i, io_wr_i, io_rd_i, cpu_halt_o, ready_irq_o;
   logic [5:0] io_addr_i;
   logic [7:0] io_wdata_i, io_rdata_o;
   logic [1:0] act [4] = '{2'h0, 2'h1, 2'h2, 2'h2};
   logic [7:0] dat [4] = '{8'h5a, 8'h00, 8'h3c, 8'hf0};
   logic [7:0] exq [4] = '{8'h5a, 8'hff, 8'h3c, 8'h30};
   int         mismatches, check_count, n, i;
   // short program times keep the run brief
   nvra_top #(.ATOMIC_CYC(20), .SPLIT_CYC(10)) dut_u (.clk_i(clk_i), .rstn_i(rstn_i),
      .por_n_i(por_n_i), .io_addr_i(io_addr_i), .io_wr_i(io_wr_i), .io_rd_i(io_rd_i),
      .io_wdata_i(io_wdata_i), .io_rdata_o(io_rdata_o), .cpu_halt_o(cpu_halt_o),
      .ready_irq_o(ready_irq_o));
   // ********************
   // access tasks
   // ********************
   task automatic cmp(input string nm, input logic [7:0] e, input logic [7:0] g);
      check_count++;
      if (g !== e) begin
         mismatches++;
         $display("wrong value %s expected %h seen %h", nm, e, g);
      end
   endtask
   task automatic wr(input logic [5:0] a, input logic [7:0] d);
      @(posedge clk_i);
      io_addr_i <= a;
      io_wdata_i <= d;
      io_wr_i <= 1'b1;
      @(posedge clk_i);
      io_wr_i <= 1'b0;
   endtask
   task automatic rd(input logic [5:0] a, input logic [7:0] e, input string nm);
      @(posedge clk_i);
      io_addr_i <= a;
      io_rd_i <= 1'b1;
      @(posedge clk_i);
      io_rd_i <= 1'b0;
      #1 cmp(nm, e, io_rdata_o);
   endtask
   task automatic pulse_reset;
      rstn_i <= 1'b0;
      repeat (3) @(posedge clk_i);
      rstn_i <= 1'b1;
      repeat (3) @(posedge clk_i);
   endtask
   task automatic final_report;
      $display("checks %0d mismatches %0d", check_count, mismatches);
      if (mismatches == 0 && check_count > 0)
         $display("TB: PASS");
      else
         $display("TB: FAIL");
      $finish;
   endtask
   // ********************
   // sequence
   // ********************
   initial begin
      clk_i = 1'b0;
      forever #20 clk_i = ~clk_i;
   end
   initial begin
      #100000;
      mismatches++;
      final_report();
   end
   initial begin
      {rstn_i, por_n_i, io_wr_i, io_rd_i, io_addr_i, io_wdata_i} = '0;
      repeat (12) @(posedge clk_i);
      rstn_i <= 1'b1;
      por_n_i <= 1'b1;
      repeat (3) @(posedge clk_i);
      rd(6'h1f, 8'h00, "control reset");
      rd(6'h20, 8'h00, "data reset");
      wr(6'h22, 8'hfa);
      rd(6'h22, 8'h0a, "address high");
      wr(6'h21, 8'hbc);
      wr(6'h1f, 8'hf8);
      rd(6'h1f, 8'h38, "control spare");
      rd(6'h23, 8'h00, "unmapped");
      $display("test registers done");
      for (i = 0; i < 4; i++) begin
         wr(6'h20, dat[i]);
         wr(6'h1f, 8'h0c);
         wr(6'h1f, {2'h0, act[i], 4'ha});
         wr(6'h21, 8'h00);
         wr(6'h1f, 8'h39);
         n = 4;
         #1;
         while (ready_irq_o !== 1'b1 && n < 200) begin
            @(posedge clk_i);
            #1 n++;
         end
         cmp("busy span", (act[i] == 2'h0) ? 8'd20 : 8'd10, n[7:0]);
         rd(6'h21, 8'hbc, "address held");
         rd(6'h1f, {2'h0, act[i], 4'h8}, "action held");
         wr(6'h1f, 8'h09);
         rd(6'h20, exq[i], "array byte");
      end
      $display("test programming done");
      wr(6'h1f, 8'h0c);
      // fire lands on the fifth edge after arming, one past the window
      repeat (3) @(posedge clk_i);
      wr(6'h1f, 8'h0a);
      repeat (2) @(posedge clk_i);
      #1 cmp("late fire", 8'h01, {7'h0, ready_irq_o});
      wr(6'h1f, 8'h0c);
      wr(6'h1f, 8'h3a);
      repeat (2) @(posedge clk_i);
      #1 cmp("reserved action", 8'h01, {7'h0, ready_irq_o});
      $display("test arming done");
      wr(6'h1f, 8'h1c);
      wr(6'h1f, 8'h1a);
      pulse_reset();
      rd(6'h1f, 8'h12, "busy through reset");
      repeat (12) @(posedge clk_i);
      rd(6'h1f, 8'h10, "done after reset");
      pulse_reset();
      rd(6'h1f, 8'h00, "idle reset");
      $display("test reset done");
      wr(6'h1f, 8'h08);
      #1 cmp("ready level", 8'h01, {7'h0, ready_irq_o});
      wr(6'h1f, 8'h00);
      $display("test ready done");
      final_report();
   end
endmodule // testbench

bind nvra_top nvra_chk chk_u (.clk_i(clk_i), .rstn_i(rstn_i), .por_n_i(por_n_i),
   .io_addr_i(io_addr_i), .io_wr_i(io_wr_i), .io_rd_i(io_rd_i), .io_wdata_i(io_wdata_i),
   .io_rdata_o(io_rdata_o), .cpu_halt_o(cpu_halt_o), .ready_irq_o(ready_irq_o));
